// ===== src/cbsh_pkg.sv
/*
  Constants, register map and types for the component bin sorter with
  handler port. Assumes a 50 MHz pclk and an APB master with 32-bit data.
*/
// Overview of operation
// RULE1: Three primary limit sets, one secondary, five grades
// RULE2: Primary comparator counts only when switched on
// RULE3: Secondary comparator counts only when switched on
// RULE4: Ordered, absolute and percent primary comparison modes
// RULE5: Deviation modes compare against nominal offsets
// RULE6: Ordered mode uses absolute limits, ascending order
// RULE7: Absolute is X minus Y; percent divides
// RULE8: Upper not above lower means grade unused
// RULE9: Both on: qualified only if both pass
// RULE10: Grades, done strobe and start are low-active
// RULE11: Start pulse at least 1us, rising edge
// RULE12: Done strobe only while result is valid
// RULE13: Conversion done marks end of conversion
// RULE14: Nominal value held in its own register
// RULE15: One measurement per accepted start pulse
// RULE16: Lowest numbered passing grade wins
// RULE17: Done released on start, grades held
package cbsh_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int NUM_W        = 48;
  localparam int NUM_PRI_SETS = 3;
  localparam int NUM_WINDOWS  = NUM_PRI_SETS + 1;
  localparam int SEC_WIN      = NUM_PRI_SETS;
  localparam int CLK_PERIOD_NS    = 20;
  localparam int START_MIN_NS     = 1000;
  localparam int START_MIN_CYC    =
    (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERCENT_SCALE    = 100;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_NOMINAL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LIM_LO  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LIM_END = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PRI_VAL = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_SEC_VAL = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_CMP_VAL = 8'h34;
  localparam int LIM_STRIDE_SH = 3;
  localparam int LIM_HI_BIT    = 2;

  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int CTRL_PRI_ON  = 0;
  localparam int CTRL_AUX_ON  = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_MODE_HI = 3;
  localparam int CTRL_PULSE   = 4;
  localparam int CTRL_W       = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_GRADE_LO  = 2;
  localparam int ST_GRADE_HI  = 4;
  localparam int ST_DIVZ_BIT  = 5;
  localparam int ST_ORDER_BIT = 6;

  typedef enum logic [1:0] {
    MODE_ORDERED  = 2'h0,
    MODE_ABS_DEV  = 2'h1,
    MODE_PCT_DEV  = 2'h2
  } cbsh_mode_t;

  typedef enum logic [2:0] {
    GRADE_NONE   = 3'h0,
    GRADE_ONE    = 3'h1,
    GRADE_TWO    = 3'h2,
    GRADE_THREE  = 3'h3,
    GRADE_SEC    = 3'h4,
    GRADE_REJECT = 3'h5
  } cbsh_grade_t;

  typedef enum {
    ST_IDLE,
    ST_CONVERT,
    ST_DIVIDE,
    ST_JUDGE
  } cbsh_state_t;

endpackage

// ===== src/cbsh_window.sv
/*
  Limit window check for one grade: inclusive range test.
  Assumes signed two's complement value and limits.
*/
`timescale 1ns/1ns
module cbsh_window #(
  parameter int W = 32
) (
  input  wire logic signed [W-1:0] value,
  input  wire logic signed [W-1:0] lower,
  input  wire logic signed [W-1:0] upper,
  output logic                     pass
);

  // ----------------------------------------------------------------
  // Range test
  // ----------------------------------------------------------------
  assign pass = (upper > lower) && (value >= lower) && (value <= upper); // RULE8

endmodule

// ===== src/cbsh_divider.sv
/*
  Signed restoring divider, one quotient bit per clock, result truncated
  toward zero. Assumes start is a one-cycle pulse while not busy.
*/
`timescale 1ns/1ns
module cbsh_divider #(
  parameter int NW = 48,
  parameter int DW = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire logic signed [NW-1:0] num,
  input  wire logic signed [DW-1:0] den,
  output logic                      done,
  output logic                      div_zero,
  output logic signed [NW-1:0]      quot
);

  localparam int CW = $clog2(NW + 1);

  logic [DW:0]    rem_q;
  logic [NW-1:0]  q_q;
  logic [DW-1:0]  d_q;
  logic [CW-1:0]  cnt_q;
  logic           busy_q;
  logic           neg_q;
  logic [DW:0]    shifted;
  logic [DW:0]    trial;

  assign shifted = {rem_q[DW-1:0], q_q[NW-1]};
  assign trial   = shifted - {1'b0, d_q};

  // ----------------------------------------------------------------
  // Iteration
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q    <= '0;
      q_q      <= '0;
      d_q      <= '0;
      cnt_q    <= '0;
      busy_q   <= 1'b0;
      neg_q    <= 1'b0;
      done     <= 1'b0;
      div_zero <= 1'b0;
      quot     <= '0;
    end else begin
      done <= 1'b0;
      if (start && den == '0) begin
        done     <= 1'b1;
        div_zero <= 1'b1;
        quot     <= '0;
      end else if (start) begin
        div_zero <= 1'b0;
        rem_q    <= '0;
        q_q      <= num[NW-1] ? NW'(-num) : num;
        d_q      <= den[DW-1] ? DW'(-den) : den;
        neg_q    <= num[NW-1] ^ den[DW-1];
        cnt_q    <= CW'(NW);
        busy_q   <= 1'b1;
      end else if (busy_q && cnt_q == '0) begin
        busy_q <= 1'b0;
        done   <= 1'b1;
        quot   <= neg_q ? NW'(-q_q) : q_q;
      end else if (busy_q) begin
        cnt_q <= cnt_q - CW'(1);
        if (!trial[DW]) begin
          rem_q <= trial;
          q_q   <= {q_q[NW-2:0], 1'b1};
        end else begin
          rem_q <= shifted;
          q_q   <= {q_q[NW-2:0], 1'b0};
        end
      end
    end
  end

endmodule

// ===== src/cbsh_sorter.sv
/*
  Component bin sorter with handler port and APB register file.
  Assumes measurement readings arrive from front-end logic on pclk with a
  one-cycle valid, and the handler start pin is asynchronous.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module cbsh_sorter #(
  parameter int START_MIN = cbsh_pkg::START_MIN_CYC
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [cbsh_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [cbsh_pkg::DATA_W-1:0]  pwdata,
  output logic      [cbsh_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         start_pulse_in_n,
  input  wire logic [cbsh_pkg::DATA_W-1:0]  meas_primary,
  input  wire logic [cbsh_pkg::DATA_W-1:0]  meas_secondary,
  input  wire logic                         meas_valid,
  output logic                              meas_start,
  output logic                              grade_one_pass_n,
  output logic                              grade_two_pass_n,
  output logic                              grade_three_pass_n,
  output logic                              secondary_grade_n,
  output logic                              reject_out_n,
  output logic                              measure_done_n,
  output logic                              conversion_done_n
);
  import cbsh_pkg::*;

  localparam int LCW = $clog2(START_MIN + 1);
  localparam logic signed [NUM_W-1:0] PCT_K = NUM_W'(PERCENT_SCALE);

  // ----------------------------------------------------------------
  // Saturate a wide signed value to the data width
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] sat32(
    input logic signed [NUM_W-1:0] v
  );
    logic signed [NUM_W-1:0] max_v;
    logic signed [NUM_W-1:0] min_v;
    max_v = NUM_W'({1'b0, {(DATA_W-1){1'b1}}});
    min_v = -max_v - NUM_W'(1);
    if (v > max_v) begin
      sat32 = max_v[DATA_W-1:0];
    end else if (v < min_v) begin
      sat32 = min_v[DATA_W-1:0];
    end else begin
      sat32 = v[DATA_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_q;
  logic [DATA_W-1:0]  nominal_q;
  logic [DATA_W-1:0]  lo_q [NUM_WINDOWS];
  logic [DATA_W-1:0]  hi_q [NUM_WINDOWS];
  logic [DATA_W-1:0]  pri_q;
  logic [DATA_W-1:0]  sec_q;
  logic [DATA_W-1:0]  cmp_q;
  cbsh_grade_t        grade_q;
  cbsh_state_t        state_q;
  logic               s1_q;
  logic               s2_q;
  logic               s3_q;
  logic [LCW-1:0]     low_cnt_q;
  logic               div_start_q;
  logic               div_done;
  logic               div_zero;
  logic signed [NUM_W-1:0] quot;
  logic signed [NUM_W-1:0] diff_w;
  logic               start_ok;
  logic               pri_on;
  logic               aux_on;
  cbsh_mode_t         mode;
  logic [NUM_WINDOWS-1:0] pass;
  logic               order_err;
  logic               wr_en;
  logic               rd_phase;
  logic               lim_hit;
  logic [1:0]         lim_idx;
  logic               lim_hi;
  logic [DATA_W-1:0]  rd_val;
  logic               rd_err;
  logic [DATA_W-1:0]  win_val [NUM_WINDOWS];

  assign pri_on  = ctrl_q[CTRL_PRI_ON];
  assign aux_on  = ctrl_q[CTRL_AUX_ON];
  assign mode    = cbsh_mode_t'(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO]);
  assign diff_w  = NUM_W'($signed(pri_q)) - NUM_W'($signed(nominal_q));

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign rd_phase = psel && penable && !pready;
  assign wr_en    = psel && penable && pready && pwrite;
  assign lim_hit  = (paddr >= OFS_LIM_LO) && (paddr < OFS_LIM_END);
  assign lim_idx  = 2'((paddr - OFS_LIM_LO) >> LIM_STRIDE_SH);
  assign lim_hi   = paddr[LIM_HI_BIT];

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      rd_err = 1'b1;
    end else if (paddr == OFS_CTRL) begin
      rd_val = DATA_W'(ctrl_q);
    end else if (paddr == OFS_NOMINAL) begin
      rd_val = nominal_q;
    end else if (lim_hit) begin
      rd_val = lim_hi ? hi_q[lim_idx] : lo_q[lim_idx];
    end else if (paddr == OFS_STATUS) begin
      rd_val[ST_BUSY_BIT]  = (state_q != ST_IDLE);
      rd_val[ST_VALID_BIT] = !measure_done_n;
      rd_val[ST_GRADE_HI:ST_GRADE_LO] = grade_q;
      rd_val[ST_DIVZ_BIT]  = div_zero;
      rd_val[ST_ORDER_BIT] = order_err;
    end else if (paddr == OFS_PRI_VAL) begin
      rd_val = pri_q;
    end else if (paddr == OFS_SEC_VAL) begin
      rd_val = sec_q;
    end else if (paddr == OFS_CMP_VAL) begin
      rd_val = cmp_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (rd_phase) begin
      pready  <= 1'b1;
      pslverr <= rd_err;
      prdata  <= pwrite ? '0 : rd_val;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control and nominal registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RESET;
      nominal_q <= '0;
    end else if (wr_en && !pslverr) begin
      if (paddr == OFS_CTRL) begin
        ctrl_q <= pwdata[CTRL_W-1:0];
      end else if (paddr == OFS_NOMINAL) begin
        nominal_q <= pwdata; // RULE14
      end
    end
  end

  // ----------------------------------------------------------------
  // Limit registers: three primary sets and the secondary pair
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_WINDOWS; i++) begin
        lo_q[i] <= '0;
        hi_q[i] <= '0;
      end
    end else if (wr_en && !pslverr && lim_hit) begin
      if (lim_hi) begin
        hi_q[lim_idx] <= pwdata; // RULE1
      end else begin
        lo_q[lim_idx] <= pwdata; // RULE1
      end
    end
  end

  // Ascending order check of primary sets
  assign order_err = (mode == MODE_ORDERED) &&
    (($signed(lo_q[1]) < $signed(hi_q[0])) ||
     ($signed(lo_q[2]) < $signed(hi_q[1]))); // RULE6

  // ----------------------------------------------------------------
  // Start pin: synchroniser, low-width qualifier, rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= start_pulse_in_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= '0;
    end else if (s2_q) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != LCW'(START_MIN)) begin
      low_cnt_q <= low_cnt_q + LCW'(1); // RULE11
    end
  end

  assign start_ok = ctrl_q[CTRL_PULSE] && !s3_q && s2_q &&
                    (low_cnt_q == LCW'(START_MIN)); // RULE10 RULE11

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_WINDOWS; i++) begin
      win_val[i] = (i == SEC_WIN) ? sec_q : cmp_q; // RULE2 RULE3
    end
  end

  for (genvar g = 0; g < NUM_WINDOWS; g++) begin : g_win
    cbsh_window #(
      .W (DATA_W)
    ) u_win (
      .value (win_val[g]),
      .lower (lo_q[g]),
      .upper (hi_q[g]),
      .pass  (pass[g])
    );
  end

  cbsh_divider #(
    .NW (NUM_W),
    .DW (DATA_W)
  ) u_div (
    .clk      (pclk),
    .rst_n    (presetn),
    .start    (div_start_q),
    .num      (diff_w * PCT_K),
    .den      (nominal_q),
    .done     (div_done),
    .div_zero (div_zero),
    .quot     (quot)
  );

  // ----------------------------------------------------------------
  // Grade decision
  // ----------------------------------------------------------------
  function automatic cbsh_grade_t decide(
    input logic [NUM_WINDOWS-1:0] p,
    input logic                   pon,
    input logic                   aon
  );
    cbsh_grade_t pg;
    pg = GRADE_REJECT;
    if (p[0]) begin
      pg = GRADE_ONE; // RULE16
    end else if (p[1]) begin
      pg = GRADE_TWO;
    end else if (p[2]) begin
      pg = GRADE_THREE;
    end
    if (pon && aon) begin
      decide = p[SEC_WIN] ? pg : GRADE_REJECT; // RULE9
    end else if (pon) begin
      decide = pg; // RULE2
    end else if (aon) begin
      decide = p[SEC_WIN] ? GRADE_SEC : GRADE_REJECT; // RULE3
    end else begin
      decide = GRADE_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Measurement sequence
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= ST_IDLE;
      meas_start        <= 1'b0;
      div_start_q       <= 1'b0;
      pri_q             <= '0;
      sec_q             <= '0;
      cmp_q             <= '0;
      grade_q           <= GRADE_NONE;
      measure_done_n    <= 1'b1;
      conversion_done_n <= 1'b1;
    end else begin
      meas_start  <= 1'b0;
      div_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_ok) begin
            meas_start        <= 1'b1; // RULE15
            measure_done_n    <= 1'b1; // RULE17
            conversion_done_n <= 1'b1;
            state_q           <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (meas_valid) begin
            pri_q             <= meas_primary;
            sec_q             <= meas_secondary;
            conversion_done_n <= 1'b0; // RULE13
            state_q           <= ST_DIVIDE;
            div_start_q       <= 1'b1;
          end
        end
        ST_DIVIDE: begin
          if (mode == MODE_ORDERED) begin
            cmp_q   <= pri_q; // RULE6
            state_q <= ST_JUDGE;
          end else if (mode == MODE_ABS_DEV) begin
            cmp_q   <= sat32(diff_w); // RULE5 RULE7
            state_q <= ST_JUDGE;
          end else if (mode != MODE_PCT_DEV) begin
            cmp_q   <= pri_q;
            state_q <= ST_JUDGE;
          end else if (div_done && !div_start_q) begin
            cmp_q   <= sat32(quot); // RULE4 RULE7
            state_q <= ST_JUDGE;
          end
        end
        ST_JUDGE: begin
          grade_q        <= decide(pass, pri_on, aux_on);
          measure_done_n <= 1'b0; // RULE12
          state_q        <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Handler outputs, low-active, held until next result
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grade_one_pass_n   <= 1'b1;
      grade_two_pass_n   <= 1'b1;
      grade_three_pass_n <= 1'b1;
      secondary_grade_n  <= 1'b1;
      reject_out_n       <= 1'b1;
    end else if (state_q == ST_JUDGE) begin
      grade_one_pass_n   <= !(decide(pass, pri_on, aux_on) == GRADE_ONE);
      grade_two_pass_n   <= !(decide(pass, pri_on, aux_on) == GRADE_TWO);
      grade_three_pass_n <= !(decide(pass, pri_on, aux_on) == GRADE_THREE);
      secondary_grade_n  <= !(decide(pass, pri_on, aux_on) == GRADE_SEC);
      reject_out_n       <= !(decide(pass, pri_on, aux_on) ==
                              GRADE_REJECT); // RULE10 RULE17
    end
  end

endmodule

// ===== bench/cbsh_sorter_props.sv
/*
  Checker for the sorter's APB and handler ports.
  Assumes it is bound into cbsh_sorter.
*/
`timescale 1ns/1ns
module cbsh_sorter_props #(
  parameter int START_MIN = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_pulse_in_n,
  input wire logic meas_start,
  input wire logic grade_one_pass_n,
  input wire logic grade_two_pass_n,
  input wire logic grade_three_pass_n,
  input wire logic secondary_grade_n,
  input wire logic reject_out_n,
  input wire logic measure_done_n,
  input wire logic conversion_done_n
);
  wire [4:0] g = {grade_one_pass_n, grade_two_pass_n, grade_three_pass_n,
                  secondary_grade_n, reject_out_n};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && $rose(penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  chk_apb_wait: assert property (s_access |-> s_one_wait)
    else $error("pready not after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_grade_onehot: assert property ($countones(~g) <= 1)
    else $error("more than one grade low");
  chk_start_clear: assert property (meas_start |-> measure_done_n && conversion_done_n)
    else $error("done not released on start");
  chk_grade_hold: assert property (measure_done_n && $past(measure_done_n) |-> $stable(g))
    else $error("grades moved while not done");
  chk_done_valid: assert property (!measure_done_n && $past(!measure_done_n) |-> $stable(g))
    else $error("grades moved while done");
  chk_conv_first: assert property ($fell(measure_done_n) |-> !conversion_done_n)
    else $error("done before conversion");
  chk_one_meas: assert property (meas_start |=> !meas_start [*3])
    else $error("second start too soon");
  chk_start_edge: assert property (meas_start |->
    $past(start_pulse_in_n, 3) && !$past(start_pulse_in_n, 4))
    else $error("start without pin rise");
endmodule

bind cbsh_sorter cbsh_sorter_props #(.START_MIN(START_MIN)) u_props (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .start_pulse_in_n,
  .meas_start, .grade_one_pass_n, .grade_two_pass_n, .grade_three_pass_n,
  .secondary_grade_n, .reject_out_n, .measure_done_n, .conversion_done_n
);

// ===== bench/cbsh_handler_model.sv
/*
  Handler and front end model: start pin pulses, readings on request.
  Assumes pclk domain readings and a one-cycle valid.
*/
`timescale 1ns/1ns
module cbsh_handler_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        meas_start,
  input  wire logic [31:0] prim,
  input  wire logic [31:0] sec,
  input  wire logic [3:0]  dly,
  output logic             start_pulse_in_n,
  output logic             meas_valid,
  output logic [31:0]      meas_primary,
  output logic [31:0]      meas_secondary
);
  logic [4:0] cnt_q;
  initial start_pulse_in_n = 1'b1;
  task automatic trigger(input int low);
    @(posedge pclk);
    start_pulse_in_n <= 1'b0;
    repeat (low) @(posedge pclk);
    start_pulse_in_n <= 1'b1;
  endtask
  // Readings scrambled outside valid
  assign meas_primary   = meas_valid ? prim : ~prim;
  assign meas_secondary = meas_valid ? sec : ~sec;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= 5'h00;
      meas_valid <= 1'b0;
    end else begin
      meas_valid <= (cnt_q == 5'h01);
      if (meas_start) cnt_q <= 5'(dly) + 5'h02;
      else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

// ===== bench/tb_cbsh_sorter.sv
/*
  Self-checking bench for cbsh_sorter over APB and the handler port.
  Assumes the handler model drives the start pin and readings.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_cbsh_sorter;
  import cbsh_pkg::*;
  localparam int SMIN = 3;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prim = 0, sec = 0, prdata;
  logic [31:0] meas_primary, meas_secondary, lfsr_q = 32'hA34A;
  logic [3:0]  dly = 0;
  logic pready, pslverr, meas_valid, meas_start, start_pulse_in_n;
  logic grade_one_pass_n, grade_two_pass_n, grade_three_pass_n;
  logic secondary_grade_n, reject_out_n, measure_done_n, conversion_done_n;
  int err_total = 0, num_checks = 0;
  wire [4:0] g = {grade_one_pass_n, grade_two_pass_n, grade_three_pass_n,
                  secondary_grade_n, reject_out_n};
  always #10 pclk = ~pclk;
  cbsh_sorter #(.START_MIN(SMIN)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_pulse_in_n,
    .meas_primary, .meas_secondary, .meas_valid, .meas_start,
    .grade_one_pass_n, .grade_two_pass_n, .grade_three_pass_n,
    .secondary_grade_n, .reject_out_n, .measure_done_n, .conversion_done_n);
  cbsh_handler_model hm (.pclk, .presetn, .meas_start, .prim, .sec, .dly,
    .start_pulse_in_n, .meas_valid, .meas_primary, .meas_secondary);
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  function automatic int rs();
    return int'(rnd() % 32'd256) - 128;
  endfunction
  function automatic longint exp_val(logic [4:0] c, int nom, int x);
    if (c[3:2] == 2'h1) return longint'(x) - nom;
    if (c[3:2] != 2'h2) return longint'(x);
    if (nom == 0) return 0;
    return (longint'(x) - nom) * PERCENT_SCALE / nom;
  endfunction
  function automatic logic [2:0] exp_code(logic [4:0] c, int nom,
      int lo[4], int hi[4], int x, int s);
    longint v;
    int p;
    logic sp;
    v = exp_val(c, nom, x);
    p = 0;
    for (int i = 2; i >= 0; i--) begin
      if (hi[i] > lo[i] && v >= lo[i] && v <= hi[i]) p = i + 1;
    end
    sp = hi[3] > lo[3] && s >= lo[3] && s <= hi[3];
    if (c[0] && c[1]) return (p != 0 && sp) ? 3'(p) : 3'h5;
    if (c[0]) return (p != 0) ? 3'(p) : 3'h5;
    if (c[1]) return sp ? 3'h4 : 3'h5;
    return 3'h0;
  endfunction
  function automatic logic [4:0] outs(logic [2:0] e);
    logic [4:0] o;
    o = 5'h1F;
    if (e inside {3'h1, 3'h2, 3'h3}) o[5 - e] = 1'b0;
    if (e == 3'h4) o[1] = 1'b0;
    if (e == 3'h5) o[0] = 1'b0;
    return o;
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done(input logic lvl);
    while (measure_done_n !== lvl) @(posedge pclk);
  endtask
  task report_and_stop();
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end
  initial begin
    int lo[4], hi[4];
    int nom, x, s;
    logic [4:0] c;
    logic [2:0] e;
    logic [31:0] q;
    logic er, ord;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({g, measure_done_n, conversion_done_n}, 7'h7F)
    apb(1'b0, OFS_CTRL, 32'h0, q, er);
    `CHK(q, 32'h0)
    apb(1'b0, 8'h40, 32'h0, q, er);
    `CHK({er, q}, {1'b1, 32'h0})
    apb(1'b1, OFS_STATUS, 32'hFFFFFFFF, q, er);
    apb(1'b0, OFS_STATUS, 32'h0, q, er);
    `CHK(q, 32'h0)
    for (int n = 0; n < 14; n++) begin
      c = (n < 12) ? {1'b1, 2'(n % 3), 2'(n / 3)}
                   : {3'(n - 6), 2'h3};
      nom = (n == 12) ? 0 : 20 + int'(rnd() % 32'd64);
      for (int i = 0; i < 4; i++) begin
        lo[i] = rs();
        hi[i] = lo[i] + int'(rnd() % 32'd128) - 16;
        apb(1'b1, 8'(OFS_LIM_LO + 8 * i), 32'(lo[i]), q, er);
        apb(1'b1, 8'(OFS_LIM_LO + 8 * i + 4), 32'(hi[i]), q, er);
      end
      apb(1'b1, OFS_NOMINAL, 32'(nom), q, er);
      apb(1'b0, OFS_NOMINAL, 32'h0, q, er);
      `CHK(q, 32'(nom))
      apb(1'b1, OFS_CTRL, 32'(c), q, er);
      x = (n % 2 == 1) ? lo[n % 3] + 5 + ((c[3:2] == 2'h1) ? nom : 0) : rs();
      s = (n % 4 < 2) ? lo[3] + 3 : rs();
      prim <= 32'(x);
      sec  <= 32'(s);
      dly  <= 4'(rnd() % 32'd8);
      hm.trigger(SMIN + 1);
      wait_done(1'b1);
      wait_done(1'b0);
      e = exp_code(c, nom, lo, hi, x, s);
      `CHK(g, outs(e))
      `CHK(conversion_done_n, 1'b0)
      ord = c[3:2] == 2'h0 && (lo[1] < hi[0] || lo[2] < hi[1]);
      apb(1'b0, OFS_STATUS, 32'h0, q, er);
      `CHK(q[6:0], {ord, nom == 0, e, 2'h2})
      apb(1'b0, OFS_CMP_VAL, 32'h0, q, er);
      `CHK(q, 32'(exp_val(c, nom, x)))
    end
    hm.trigger(1);
    repeat (20) @(posedge pclk);
    `CHK(measure_done_n, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h3, q, er);
    hm.trigger(SMIN + 1);
    repeat (20) @(posedge pclk);
    `CHK(measure_done_n, 1'b0)
    report_and_stop();
  end
endmodule
